// ==== core/lsw_defs.svh ====
`ifndef LSW_DEFS_SVH
`define LSW_DEFS_SVH

// bank geometry
`define LSW_NUM_PINS 64
`define LSW_NUM_PHASES 8
`define LSW_ADDR_W 7
`define LSW_DATA_W 8

// register map: one byte per pin at offset equal to the pin number
`define LSW_PIN_BASE 7'h00
`define LSW_PIN_LAST 7'h3f
`define LSW_STATUS_ADDR 7'h40

// status register fields
`define LSW_STAT_PHASE_LSB 0
`define LSW_STAT_PHASE_MSB 2
`define LSW_STAT_GLOBAL_EN 3
`define LSW_STAT_STOP 4

// values that stand in the logic
`define LSW_ZERO_BYTE 8'h00
`define LSW_ZERO_PHASE 3'h0

`endif

// ==== core/lsw_pkg.sv ====
`include "lsw_defs.svh"

package lsw_pkg;
   typedef logic [`LSW_DATA_W-1:0] lsw_byte_type;
   typedef logic [`LSW_ADDR_W-1:0] lsw_addr_type;
   typedef logic [2:0] lsw_phase_type;
endpackage

// ==== core/lsw_segment_phase_bank.sv ====
`timescale 1ns/1ps
`include "lsw_defs.svh"
module lsw_segment_phase_bank
   import lsw_pkg::*;
#(
   parameter int NUM_PINS = `LSW_NUM_PINS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire lsw_addr_type addr_i,
   input wire lsw_byte_type wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output lsw_byte_type rdata_o,
   input wire lsw_phase_type phase_i,
   input wire logic lcd_global_enable_i,
   input wire logic [NUM_PINS-1:0] pin_lcd_enable_bit_i,
   input wire logic [NUM_PINS-1:0] backplane_select_bit_i,
   input wire logic deep_stop_mode_i,
   output logic [NUM_PINS-1:0] lcd_owned_o,
   output logic [NUM_PINS-1:0] segment_on_o,
   output logic [NUM_PINS-1:0] backplane_active_o
);

   // no reset on the bank: contents are undefined until written, and keeping
   // the flops off the reset net is what lets them ride through deep stop
   lsw_byte_type segment_phase_pattern_regs [NUM_PINS];
   lsw_byte_type rdata_r;
   lsw_byte_type status_byte;
   logic [NUM_PINS-1:0] owned_nxt;
   logic [NUM_PINS-1:0] seg_nxt;
   logic [NUM_PINS-1:0] bp_nxt;
   logic [NUM_PINS-1:0] owned_r;
   logic [NUM_PINS-1:0] seg_r;
   logic [NUM_PINS-1:0] bp_r;
   logic pin_hit;

   assign pin_hit = (addr_i >= `LSW_PIN_BASE) && (addr_i <= `LSW_PIN_LAST)
                    && (int'(addr_i) < NUM_PINS);

   // byte-wide port only, so a word write cannot tear a pattern here
   always_ff @(posedge clk_i) begin
      if (wr_i && pin_hit && !deep_stop_mode_i) begin
         segment_phase_pattern_regs[addr_i[5:0]] <= wdata_i;
      end
   end

   always_comb begin
      status_byte = `LSW_ZERO_BYTE;
      status_byte[`LSW_STAT_PHASE_MSB:`LSW_STAT_PHASE_LSB] = phase_i;
      status_byte[`LSW_STAT_GLOBAL_EN] = lcd_global_enable_i;
      status_byte[`LSW_STAT_STOP] = deep_stop_mode_i;
   end

   // read data stand only in the cycle after the read strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= `LSW_ZERO_BYTE;
      end else if (rd_i && pin_hit) begin
         rdata_r <= segment_phase_pattern_regs[addr_i[5:0]];
      end else if (rd_i && addr_i == `LSW_STATUS_ADDR) begin
         rdata_r <= status_byte;
      end else begin
         rdata_r <= `LSW_ZERO_BYTE;
      end
   end

   assign rdata_o = rdata_r;

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         logic phase_bit;
         logic active;
         assign phase_bit = segment_phase_pattern_regs[g][phase_i];
         // pins are released while asleep; the pattern itself is kept
         assign active = lcd_global_enable_i && pin_lcd_enable_bit_i[g]
                         && !deep_stop_mode_i;
         assign owned_nxt[g] = active;
         assign seg_nxt[g] = active && !backplane_select_bit_i[g] && phase_bit;
         assign bp_nxt[g] = active && backplane_select_bit_i[g] && phase_bit;
      end
   endgenerate

   // an unwritten pattern is undefined, so the segment_on_o or backplane_active_o bit of an
   // enabled pin that was never written is undefined too; software writes before enabling
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         owned_r <= '0;
         seg_r <= '0;
         bp_r <= '0;
      end else begin
         owned_r <= owned_nxt;
         seg_r <= seg_nxt;
         bp_r <= bp_nxt;
      end
   end

   assign lcd_owned_o = owned_r;
   assign segment_on_o = seg_r;
   assign backplane_active_o = bp_r;

endmodule

// ==== testbench/lcd_segment_waveform_bank_tb_top.sv ====
`timescale 1ns/1ps
module lcd_segment_waveform_bank_tb_top import lsw_pkg::*; ;
   logic clk_i = 0, rst_i = 1, lcd_global_enable_i = 0, deep_stop_mode_i = 0, wr_i, rd_i;
   logic [63:0] pin_lcd_enable_bit_i = '1, backplane_select_bit_i = 64'hffff_ffff_0000_0000;
   logic [63:0] lcd_owned_o, segment_on_o, backplane_active_o;
   lsw_phase_type phase_i = 0;
   lsw_addr_type addr_i;
   lsw_byte_type wdata_i, rdata_o;
   int error_cnt = 0, compares = 0;
   always #5 clk_i = ~clk_i;
   lsw_cpu cpu (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
   lsw_segment_phase_bank DUT (.*);
   task automatic check(logic [63:0] got, exp);
      compares++;
      error_cnt += got !== exp;
      if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
   endtask
   task automatic summarize();
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      // 0x40 and 0x41 are written too: both must refuse
      for (int p = 0; p < 66; p++) cpu.xfer(1, 7'(p), 8'(1 << p % 8));
      for (int p = 0; p < 66; p++) begin
         cpu.xfer(0, 7'(p), 0);
         #1 check(rdata_o, p < 64 ? 1 << p % 8 : 0);
      end
      @(posedge clk_i);
      lcd_global_enable_i <= 1;
      for (int f = 0; f < 8; f++) begin
         @(posedge clk_i);
         phase_i <= 3'(f);
         repeat (2) @(posedge clk_i);
         #1 check(segment_on_o, 64'h0101_0101 << f);
         check(backplane_active_o, 64'h0101_0101_0000_0000 << f);
      end
      cpu.xfer(0, 7'h40, 0);
      #1 check(rdata_o, 8'h0f);
      @(posedge clk_i);
      deep_stop_mode_i <= 1;
      cpu.xfer(1, 0, 8'hff);
      repeat (2) @(posedge clk_i);
      #1 check(lcd_owned_o, 0);
      @(posedge clk_i);
      rst_i <= 1;
      @(posedge clk_i);
      {rst_i, deep_stop_mode_i, lcd_global_enable_i} <= 0;
      cpu.xfer(0, 0, 0);
      #1 check(rdata_o, 1);
      summarize();
   end
endmodule

// ==== testbench/lsw_chk_checker.sv ====
`timescale 1ns/1ps
module lsw_chk import lsw_pkg::*; (
   input wire logic clk_i, rst_i, rd_i, lcd_global_enable_i, deep_stop_mode_i,
   input wire lsw_byte_type rdata_o,
   input wire logic [63:0] pin_lcd_enable_bit_i,
   input wire logic [63:0] lcd_owned_o, segment_on_o, backplane_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_idle_zero: assert property (!rd_i |=> !rdata_o) else $error("rdata");
   a_global_off: assert property (!lcd_global_enable_i |=> !lcd_owned_o) else $error("owned");
   a_stop_free: assert property (deep_stop_mode_i |=> !lcd_owned_o) else $error("stop");
   a_fp_owned: assert property (!(segment_on_o & ~lcd_owned_o)) else $error("seg");
   a_bp_owned: assert property (!(backplane_active_o & ~lcd_owned_o)) else $error("bp");
   a_role_excl: assert property (!(segment_on_o & backplane_active_o)) else $error("roles");
   a_owned_track: assert property (lcd_owned_o ==
      $past({64{lcd_global_enable_i && !deep_stop_mode_i}} & pin_lcd_enable_bit_i)) else $error("track");
endmodule
bind lsw_segment_phase_bank lsw_chk u_chk (.*);

// ==== testbench/lsw_cpu.sv ====
`timescale 1ns/1ps
module lsw_cpu import lsw_pkg::*; (
   input wire logic clk_i,
   output lsw_addr_type addr_o = 0,
   output lsw_byte_type wdata_o = 0,
   output logic wr_o = 0,
   output logic rd_o = 0
);
   // one byte per strobe, launched right after a rising edge
   task automatic xfer(logic w, lsw_addr_type a, lsw_byte_type d);
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
      @(posedge clk_i);
      {wr_o, rd_o} <= 0;
   endtask
endmodule
